// *** bnd_params.svh ***
/*
 * Named constants for the bit-clear / negative-branch decode block:
 * widths, opcode fields, field positions and access bank layout.
 * Assumes it is included by bare name from every file that needs it.
 */
`ifndef BND_PARAMS_SVH
`define BND_PARAMS_SVH

`define BND_INSTR_W 16
`define BND_DATA_W 8
`define BND_ADDR_W 12
`define BND_BANK_W 4
`define BND_PC_W 21
`define BND_BIT_W 3

// bit-clear word: 1001 bbba ffff ffff
`define BND_CLR_OPC_HI 15
`define BND_CLR_OPC_LO 12
`define BND_CLR_OPC 4'h9
`define BND_BIT_HI 11
`define BND_BIT_LO 9
`define BND_ACC_BIT 8
`define BND_REG_HI 7
`define BND_REG_LO 0

// negative branch word: 1110 0110 nnnn nnnn
`define BND_BR_OPC_HI 15
`define BND_BR_OPC_LO 8
`define BND_BR_OPC 8'hE6
`define BND_OFS_HI 7
`define BND_OFS_LO 0

// access bank and indexed literal offset window
`define BND_IDX_LIMIT 8'h5F
`define BND_ACC_SPLIT_BIT 7
`define BND_ACC_LOW_BANK 4'h0
`define BND_ACC_HIGH_BANK 4'hF
`define BND_BANK_PAD 4'h0

`endif

// *** bnd_pkg.sv ***
/*
 * Types for the bit-clear / negative-branch decode block: quarter-cycle
 * phases, decoded operation and the packed state of the main module.
 * Assumes bnd_params.svh is available on the include path.
 */
`include "bnd_params.svh"

package bnd_pkg;

    typedef enum logic [1:0] {
        q_decode,
        q_read,
        q_process,
        q_write
    } bnd_quarter_t;

    typedef enum logic [1:0] {
        op_none,
        op_clear,
        op_branch
    } bnd_op_t;

    typedef struct packed {
        bnd_quarter_t quarter;
        bnd_op_t op;
        logic flush_pend;
        logic nop_cycle;
        logic [`BND_BIT_W-1:0] bit_sel;
        logic [`BND_DATA_W-1:0] offset;
        logic [`BND_PC_W-1:0] pc;
        logic [`BND_ADDR_W-1:0] addr;
        logic indexed;
        logic rd;
        logic wr;
        logic [`BND_DATA_W-1:0] wdata;
        logic pc_load;
        logic [`BND_PC_W-1:0] target;
    } bnd_state_t;

endpackage : bnd_pkg

// *** bnd_addr_resolve.sv ***
/*
 * Target address resolution for the bit-clear instruction: access bank,
 * banked space through the bank selector, or indexed literal offset.
 * Assumes purely combinational use by bnd_decode on the same clock.
 */
`include "bnd_params.svh"

module bnd_addr_resolve (
    input wire logic [`BND_DATA_W-1:0] reg_field_i,
    input wire logic use_bank_i,
    input wire logic [`BND_BANK_W-1:0] bank_selector_reg_i,
    input wire logic ext_set_en_i,
    input wire logic [`BND_ADDR_W-1:0] index_base_i,
    output logic [`BND_ADDR_W-1:0] addr_o,
    output logic indexed_o
);

    logic idx_window;

    // indexed mode only below or at the offset limit
    assign idx_window = ext_set_en_i && !use_bank_i && (reg_field_i <= `BND_IDX_LIMIT);

    always_comb begin
        indexed_o = idx_window;
        if (use_bank_i) begin
            addr_o = {bank_selector_reg_i, reg_field_i};
        end else if (idx_window) begin
            addr_o = index_base_i + {`BND_BANK_PAD, reg_field_i};
        end else if (reg_field_i[`BND_ACC_SPLIT_BIT]) begin
            addr_o = {`BND_ACC_HIGH_BANK, reg_field_i};
        end else begin
            addr_o = {`BND_ACC_LOW_BANK, reg_field_i};
        end
    end

endmodule : bnd_addr_resolve

// *** bnd_decode.sv ***
/*
 * Decode and execute of the bit-clear and branch-on-negative instructions.
 * One clk_i edge is one quarter cycle; four quarters make an instruction
 * cycle. Assumes the fetch path offers a word at the decode quarter, the
 * data memory returns read data in the quarter after a read strobe, and
 * the negative flag and program counter come from logic on clk_i.
 */
`include "bnd_params.svh"

module bnd_decode (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic instr_valid_i,
    input wire logic [`BND_INSTR_W-1:0] instr_i,
    input wire logic [`BND_PC_W-1:0] pc_i,
    input wire logic neg_flag_i,
    input wire logic [`BND_BANK_W-1:0] bank_selector_reg_i,
    input wire logic ext_set_en_i,
    input wire logic [`BND_ADDR_W-1:0] index_base_i,
    input wire logic [`BND_DATA_W-1:0] mem_rdata_i,
    output logic [1:0] quarter_o,
    output logic instr_accept_o,
    output logic nop_cycle_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [`BND_ADDR_W-1:0] mem_addr_o,
    output logic mem_indexed_o,
    output logic [`BND_DATA_W-1:0] mem_wdata_o,
    output logic pc_load_o,
    output logic [`BND_PC_W-1:0] pc_target_o
);

    bnd_pkg::bnd_state_t st_r;
    bnd_pkg::bnd_state_t st_nxt;

    logic is_clear;
    logic is_branch;
    logic [`BND_DATA_W-1:0] reg_field;
    logic [`BND_BIT_W-1:0] bit_field;
    logic use_bank;
    logic [`BND_ADDR_W-1:0] resolved_addr;
    logic resolved_indexed;
    logic [`BND_DATA_W-1:0] keep_mask;
    logic [`BND_PC_W-1:0] branch_disp;

    // instruction field split
    assign is_clear = (instr_i[`BND_CLR_OPC_HI:`BND_CLR_OPC_LO] == `BND_CLR_OPC);
    assign is_branch = (instr_i[`BND_BR_OPC_HI:`BND_BR_OPC_LO] == `BND_BR_OPC);
    assign reg_field = instr_i[`BND_REG_HI:`BND_REG_LO];
    assign bit_field = instr_i[`BND_BIT_HI:`BND_BIT_LO];
    assign use_bank = instr_i[`BND_ACC_BIT];

    bnd_addr_resolve u_addr (
        .reg_field_i(reg_field),
        .use_bank_i(use_bank),
        .bank_selector_reg_i(bank_selector_reg_i),
        .ext_set_en_i(ext_set_en_i),
        .index_base_i(index_base_i),
        .addr_o(resolved_addr),
        .indexed_o(resolved_indexed)
    );

    // one mask bit per data bit: zero only at the selected position
    for (genvar i = 0; i < `BND_DATA_W; i++) begin : g_mask
        assign keep_mask[i] = (st_r.bit_sel != 3'(i));
    end

    // sign-extended offset shifted left by one, i.e. twice n
    assign branch_disp = {{(`BND_PC_W-`BND_DATA_W-1){st_r.offset[`BND_DATA_W-1]}}, st_r.offset, 1'b0};

    always_comb begin
        st_nxt = st_r;
        st_nxt.rd = 1'b0;
        st_nxt.wr = 1'b0;
        st_nxt.pc_load = 1'b0;
        unique case (st_r.quarter)
            bnd_pkg::q_decode: begin
                st_nxt.quarter = bnd_pkg::q_read;
                st_nxt.op = bnd_pkg::op_none;
                st_nxt.flush_pend = 1'b0;
                // the cycle after a taken branch executes nothing
                st_nxt.nop_cycle = st_r.flush_pend;
                if (!st_r.flush_pend && instr_valid_i) begin
                    if (is_clear) begin
                        st_nxt.op = bnd_pkg::op_clear;
                        st_nxt.bit_sel = bit_field;
                        st_nxt.addr = resolved_addr;
                        st_nxt.indexed = resolved_indexed;
                        st_nxt.rd = 1'b1;
                    end else if (is_branch) begin
                        st_nxt.op = bnd_pkg::op_branch;
                        st_nxt.offset = instr_i[`BND_OFS_HI:`BND_OFS_LO];
                        st_nxt.pc = pc_i;
                    end
                end
            end
            bnd_pkg::q_read: begin
                st_nxt.quarter = bnd_pkg::q_process;
            end
            bnd_pkg::q_process: begin
                st_nxt.quarter = bnd_pkg::q_write;
                if (st_r.op == bnd_pkg::op_clear) begin
                    // read-modify-write; no flag is touched
                    st_nxt.wdata = mem_rdata_i & keep_mask;
                    st_nxt.wr = 1'b1;
                end else if (st_r.op == bnd_pkg::op_branch && neg_flag_i) begin
                    st_nxt.target = st_r.pc + branch_disp;
                    st_nxt.pc_load = 1'b1;
                    st_nxt.flush_pend = 1'b1;
                end
            end
            bnd_pkg::q_write: begin
                st_nxt.quarter = bnd_pkg::q_decode;
                st_nxt.nop_cycle = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign quarter_o = st_r.quarter;
    assign instr_accept_o = (st_r.quarter == bnd_pkg::q_decode) && !st_r.flush_pend;
    assign nop_cycle_o = st_r.nop_cycle;
    assign mem_rd_o = st_r.rd;
    assign mem_wr_o = st_r.wr;
    assign mem_addr_o = st_r.addr;
    assign mem_indexed_o = st_r.indexed;
    assign mem_wdata_o = st_r.wdata;
    assign pc_load_o = st_r.pc_load;
    assign pc_target_o = st_r.target;

endmodule : bnd_decode

// *** bnd_decode_props.sv ***
/* assertions for bnd_decode: address, data and cycle timing of both ops.
   assumes one clock, synchronous reset, bound onto bnd_decode. */
module bnd_decode_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [20:0] pc_i,
    input wire logic neg_flag_i,
    input wire logic [3:0] bank_selector_reg_i,
    input wire logic ext_set_en_i,
    input wire logic [11:0] index_base_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic instr_accept_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic [11:0] mem_addr_o,
    input wire logic mem_indexed_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic pc_load_o,
    input wire logic [20:0] pc_target_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] bit_r;
    logic [20:0] tgt_r;
    wire acc = instr_accept_o && instr_valid_i;
    wire sel = instr_i[8];
    wire [7:0] f = instr_i[7:0];
    wire clr = acc && instr_i[15:12] == 4'h9;
    wire br = acc && instr_i[15:8] == 8'hE6;
    // remember bit index and branch target of the word just taken
    always_ff @(posedge clk_i) begin
        if (acc) begin
            bit_r <= instr_i[11:9];
            tgt_r <= pc_i + {{12{f[7]}}, f, 1'b0};
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_wdata;
        mem_wr_o |-> mem_wdata_o == ($past(mem_rdata_i) & ~(8'h01 << bit_r));
    endproperty
    a_wdata: assert property (p_wdata) else $error("cleared data wrong");
    property p_bank;
        clr && sel |=> !mem_indexed_o && mem_addr_o == {$past(bank_selector_reg_i), $past(f)};
    endproperty
    a_bank: assert property (p_bank) else $error("banked address wrong");
    property p_acc;
        clr && !sel && !ext_set_en_i |=> !mem_indexed_o && mem_addr_o == {{4{$past(f[7])}}, $past(f)};
    endproperty
    a_acc: assert property (p_acc) else $error("access bank address wrong");
    property p_idx;
        clr && !sel && ext_set_en_i && f <= 8'h5F |=> mem_indexed_o && mem_addr_o == $past(index_base_i) + $past(f);
    endproperty
    a_idx: assert property (p_idx) else $error("indexed address wrong");
    property p_lim;
        clr && !sel && ext_set_en_i && f > 8'h5F |=> !mem_indexed_o && mem_addr_o == {{4{$past(f[7])}}, $past(f)};
    endproperty
    a_lim: assert property (p_lim) else $error("field above indexed window");
    property p_clr;
        clr |=> mem_rd_o ##1 !mem_rd_o ##1 mem_wr_o ##1 (instr_accept_o && !mem_wr_o);
    endproperty
    a_clr: assert property (p_clr) else $error("clear timing wrong");
    property p_br;
        br ##2 neg_flag_i |=> pc_load_o && pc_target_o == tgt_r;
    endproperty
    a_br: assert property (p_br) else $error("branch target wrong");
    property p_brt;
        br ##2 neg_flag_i |=> ##1 !instr_accept_o ##4 instr_accept_o;
    endproperty
    a_brt: assert property (p_brt) else $error("no-op cycle wrong");
    property p_brn;
        br ##2 !neg_flag_i |=> !pc_load_o ##1 instr_accept_o;
    endproperty
    a_brn: assert property (p_brn) else $error("untaken branch wrong");
endmodule : bnd_decode_props

bind bnd_decode bnd_decode_props bnd_decode_props_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .instr_valid_i(instr_valid_i),
    .instr_i(instr_i),
    .pc_i(pc_i),
    .neg_flag_i(neg_flag_i),
    .bank_selector_reg_i(bank_selector_reg_i),
    .ext_set_en_i(ext_set_en_i),
    .index_base_i(index_base_i),
    .mem_rdata_i(mem_rdata_i),
    .instr_accept_o(instr_accept_o),
    .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o),
    .mem_indexed_o(mem_indexed_o),
    .mem_wdata_o(mem_wdata_o),
    .pc_load_o(pc_load_o),
    .pc_target_o(pc_target_o)
);

// *** testbench.sv ***
/* self-checking bench for bnd_decode: bit clear and branch on negative.
   assumes bnd_decode_props is bound to the design. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic instr_valid_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic [20:0] pc_i = 21'h00_0000;
    logic neg_flag_i = 1'b0;
    logic [3:0] bank_selector_reg_i = 4'h5;
    logic ext_set_en_i = 1'b0;
    logic [11:0] index_base_i = 12'h050;
    logic [7:0] mem_rdata_i = 8'h00;
    logic [1:0] quarter_o;
    logic instr_accept_o, nop_cycle_o, mem_rd_o, mem_wr_o, mem_indexed_o, pc_load_o;
    logic [11:0] mem_addr_o;
    logic [7:0] mem_wdata_o;
    logic [20:0] pc_target_o;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    always #5 clk_i = ~clk_i;
    bnd_decode bnd_decode_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .instr_valid_i(instr_valid_i),
        .instr_i(instr_i),
        .pc_i(pc_i),
        .neg_flag_i(neg_flag_i),
        .bank_selector_reg_i(bank_selector_reg_i),
        .ext_set_en_i(ext_set_en_i),
        .index_base_i(index_base_i),
        .mem_rdata_i(mem_rdata_i),
        .quarter_o(quarter_o),
        .instr_accept_o(instr_accept_o),
        .nop_cycle_o(nop_cycle_o),
        .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o),
        .mem_addr_o(mem_addr_o),
        .mem_indexed_o(mem_indexed_o),
        .mem_wdata_o(mem_wdata_o),
        .pc_load_o(pc_load_o),
        .pc_target_o(pc_target_o)
    );
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk
    // hold the word until a decode quarter takes it, ends on the taking edge
    task automatic issue(input logic [15:0] w);
        instr_i <= w;
        instr_valid_i <= 1'b1;
        do @(negedge clk_i); while (!(quarter_o === 2'h0 && instr_accept_o === 1'b1));
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
    endtask : issue
    task automatic t_clear(input logic s, input logic x, input logic [7:0] f, input logic [2:0] b,
                           input logic [7:0] d, input logic [11:0] ea, input logic ei);
        ext_set_en_i <= x;
        mem_rdata_i <= d;
        issue({4'h9, b, s, f});
        @(negedge clk_i);
        chk(mem_rd_o === 1'b1 && mem_addr_o === ea && mem_indexed_o === ei, "address");
        repeat (2) @(negedge clk_i);
        chk(mem_wr_o === 1'b1 && mem_wdata_o === (d & ~(8'h01 << b)), "data");
        @(posedge clk_i);
        $display("clear test done at %0t", $time);
    endtask : t_clear
    task automatic t_branch(input logic n, input logic [7:0] o, input logic [20:0] pc, input logic [20:0] t);
        pc_i <= pc;
        neg_flag_i <= n;
        issue({8'hE6, o});
        repeat (3) @(negedge clk_i);
        chk(pc_load_o === n && (!n || pc_target_o === t), "target");
        @(negedge clk_i);
        chk(instr_accept_o === !n, "no-op slot");
        @(negedge clk_i);
        chk(nop_cycle_o === n && mem_wr_o === 1'b0 && quarter_o === 2'h1, "no-op flag");
        @(posedge clk_i);
        $display("branch test done at %0t", $time);
    endtask : t_branch
    task automatic wrap_up;
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            wrap_up;
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_clear(1'b1, 1'b0, 8'h34, 3'h7, 8'hC7, 12'h534, 1'b0);
        t_clear(1'b0, 1'b0, 8'h90, 3'h0, 8'hFF, 12'hF90, 1'b0);
        t_clear(1'b0, 1'b1, 8'h5F, 3'h3, 8'h0F, 12'h0AF, 1'b1);
        t_clear(1'b0, 1'b1, 8'h60, 3'h5, 8'h20, 12'h060, 1'b0);
        t_branch(1'b1, 8'h80, 21'h00_0100, 21'h00_0000);
        t_clear(1'b1, 1'b1, 8'h12, 3'h1, 8'h02, 12'h512, 1'b0);
        t_branch(1'b1, 8'h7F, 21'h1F_FFFE, 21'h00_00FC);
        t_branch(1'b0, 8'h10, 21'h00_0200, 21'h00_0000);
        t_clear(1'b0, 1'b0, 8'h7F, 3'h6, 8'h40, 12'h07F, 1'b0);
        wrap_up;
    end
endmodule : testbench
